/* verilog/spi_port.sv */
// Byte-wide serial peripheral port, master or slave, with register port
//
// Summary of operation
// - Set transfer done after every byte.
// - Write to full buffer: collision flag, ignored.
// - Multi-master select low: fault, drop master.
// - Slave unread byte: overrun, drop new byte.
// - Four flags request interrupt; software clears.
// - Phase bit picks first or second edge.
// - Polarity bit picks idle clock level.
// - Master rate capped; rate register ignored slave.
// - Slave samples mid-bit; master before bit end.
// - Busy flag reads one during transfers.
// - Master select bit: zero slave, one master.
// - Selected flag mirrors select line low.
// - Raw bit shows select line level.
// - Shift empty flag: set done, cleared load/edge.
// - Receive empty: slave buffer state, master one.
// - Mode field: 3-wire, input, driven output.
// - Transmit empty clears on write, sets on move.
// - Data write loads buffer; read returns receive.
// - Master clock is system over two(rate+1).
// - Slave counts edges; eight bits complete byte.
// - Most significant bit first both ways.
`timescale 1ns/1ps
module spi_port (
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic [7:0] sfr_addr_i,
    input  wire logic       sfr_wr_i,
    input  wire logic       sfr_rd_i,
    input  wire logic [7:0] sfr_wdata_i,
    output logic      [7:0] sfr_rdata_o,
    input  wire logic       int_enable_i,
    output logic            irq_o,
    input  wire logic       sck_i,
    output logic            sck_o,
    output logic            sck_oe_o,
    input  wire logic       mosi_i,
    output logic            mosi_o,
    output logic            mosi_oe_o,
    input  wire logic       miso_i,
    output logic            miso_o,
    output logic            miso_oe_o,
    input  wire logic       sel_line_i,
    output logic            sel_line_o,
    output logic            sel_line_oe_o
);
    ////////////////////////////////////////////////////////////////////////////
    // Declarations
    logic       sck_s, mosi_s, miso_s, sel_s;
    logic       sck_d_r, sel_d_r;
    logic       master_r, cpha_r, cpol_r, enable_r;
    logic [1:0] mode_r;
    logic       done_flag_r, coll_flag_r, fault_flag_r, ovrn_flag_r;
    logic [7:0] rate_r;
    logic [7:0] txbuf_r, rxbuf_r, tx_sr_r, rx_sr_r;
    logic       txbuf_full_r, rx_full_r, shift_register_empty_r;
    logic [3:0] bit_cnt_r;
    spi_port_pkg::m_state_t m_state_r;
    logic       half_end, m_done, s_done, done, move;
    logic       wr_cfg, wr_ctl, wr_ckr, wr_dat, rd_dat, dat_accept, dat_coll;
    logic       slave_act, sck_edge, lead_edge, trail_edge, s_sample, s_shift;
    logic       fault, sel_fall, m_sample, tail_edge;
    logic [7:0] rx_byte, cfg_val, ctl_val;
    logic [8:0] half_len;

    // Half period in system clocks, clamped to the fastest legal master rate
    function automatic logic [8:0] half_cycles(input logic [7:0] rate);
        logic [8:0] n;
        n = {1'b0, rate} + 9'h001;
        half_cycles = (n < spi_port_pkg::MIN_HALF) ? spi_port_pkg::MIN_HALF : n;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Link pin synchronisers and master half-period timer
    pin_sync u_sync (
        .clk_i  (clk_i),
        .rst_i  (rst_i),
        .pins_i ({sck_i, mosi_i, miso_i, sel_line_i}),
        .pins_o ({sck_s, mosi_s, miso_s, sel_s})
    );

    assign half_len = half_cycles(rate_r);

    sck_half_timer u_timer (
        .clk_i      (clk_i),
        .rst_i      (rst_i),
        .run_i      (m_state_r != spi_port_pkg::M_IDLE),
        .half_len_i (half_len),
        .half_end_o (half_end)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Register port decode
    assign wr_cfg     = sfr_wr_i && (sfr_addr_i == spi_port_pkg::CFG_ADDR);
    assign wr_ctl     = sfr_wr_i && (sfr_addr_i == spi_port_pkg::CTL_ADDR);
    assign wr_ckr     = sfr_wr_i && (sfr_addr_i == spi_port_pkg::CKR_ADDR);
    assign wr_dat     = sfr_wr_i && (sfr_addr_i == spi_port_pkg::DAT_ADDR);
    assign rd_dat     = sfr_rd_i && (sfr_addr_i == spi_port_pkg::DAT_ADDR);
    assign dat_accept = wr_dat && !txbuf_full_r;
    assign dat_coll   = wr_dat && txbuf_full_r;

    // Link event decode; in multi-master mode the slave ignores the clock unless selected
    assign slave_act  = enable_r && !master_r && ((mode_r != spi_port_pkg::MODE_MULTI) || !sel_s);
    assign sck_edge   = slave_act && (sck_s != sck_d_r);
    assign lead_edge  = sck_edge && (sck_s != cpol_r);
    assign trail_edge = sck_edge && (sck_s == cpol_r);
    assign s_sample   = cpha_r ? trail_edge : lead_edge;
    assign s_shift    = cpha_r ? lead_edge : trail_edge;
    assign s_done     = s_sample && (bit_cnt_r == spi_port_pkg::BYTE_BITS - 4'h1);
    assign tail_edge  = trail_edge && !cpha_r && (bit_cnt_r == 4'h0); // Closing edge of a finished byte
    assign m_sample   = half_end && (m_state_r == spi_port_pkg::M_TRAIL);
    assign m_done     = m_sample && (bit_cnt_r == spi_port_pkg::BYTE_BITS - 4'h1);
    assign done       = m_done || s_done;
    assign sel_fall   = !sel_s && sel_d_r && (mode_r == spi_port_pkg::MODE_MULTI);
    assign fault      = enable_r && master_r && (mode_r == spi_port_pkg::MODE_MULTI) && !sel_s;
    assign rx_byte    = {rx_sr_r[6:0], master_r ? miso_s : mosi_s};

    // Transmit buffer moves to an idle shift register, or straight after a slave byte
    assign move = enable_r && txbuf_full_r && !fault &&
                  ((shift_register_empty_r && (bit_cnt_r == 4'h0) && (m_state_r == spi_port_pkg::M_IDLE)) ||
                   (s_done && !master_r));

    ////////////////////////////////////////////////////////////////////////////
    // Configuration bits; a mode fault overrides a software write
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            master_r <= spi_port_pkg::CFG_RESET[spi_port_pkg::CFG_MASTER];
            cpha_r   <= spi_port_pkg::CFG_RESET[spi_port_pkg::CFG_CPHA];
            cpol_r   <= spi_port_pkg::CFG_RESET[spi_port_pkg::CFG_CPOL];
        end else begin
            if (wr_cfg) begin
                master_r <= sfr_wdata_i[spi_port_pkg::CFG_MASTER];
                cpha_r   <= sfr_wdata_i[spi_port_pkg::CFG_CPHA];
                cpol_r   <= sfr_wdata_i[spi_port_pkg::CFG_CPOL];
            end
            if (fault) begin
                master_r <= 1'b0;
            end
        end
    end

    // Control bits and sticky flags; hardware set beats software write
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            done_flag_r  <= spi_port_pkg::CTL_RESET[spi_port_pkg::CTL_DONE];
            coll_flag_r  <= spi_port_pkg::CTL_RESET[spi_port_pkg::CTL_COLL];
            fault_flag_r <= spi_port_pkg::CTL_RESET[spi_port_pkg::CTL_FAULT];
            ovrn_flag_r  <= spi_port_pkg::CTL_RESET[spi_port_pkg::CTL_OVRN];
            mode_r       <= spi_port_pkg::CTL_RESET[spi_port_pkg::CTL_MODE_H:spi_port_pkg::CTL_MODE_L];
            enable_r     <= spi_port_pkg::CTL_RESET[spi_port_pkg::CTL_EN];
        end else begin
            if (wr_ctl) begin
                done_flag_r  <= sfr_wdata_i[spi_port_pkg::CTL_DONE];
                coll_flag_r  <= sfr_wdata_i[spi_port_pkg::CTL_COLL];
                fault_flag_r <= sfr_wdata_i[spi_port_pkg::CTL_FAULT];
                ovrn_flag_r  <= sfr_wdata_i[spi_port_pkg::CTL_OVRN];
                mode_r       <= sfr_wdata_i[spi_port_pkg::CTL_MODE_H:spi_port_pkg::CTL_MODE_L];
                enable_r     <= sfr_wdata_i[spi_port_pkg::CTL_EN];
            end
            if (done) begin
                done_flag_r <= 1'b1;
            end
            if (dat_coll) begin
                coll_flag_r <= 1'b1;
            end
            if (fault) begin
                fault_flag_r <= 1'b1;
                enable_r     <= 1'b0;
            end
            if (s_done && !master_r && rx_full_r) begin
                ovrn_flag_r <= 1'b1;
            end
        end
    end

    // Clock rate register, used by the master timer only
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            rate_r <= spi_port_pkg::CKR_RESET;
        end else if (wr_ckr) begin
            rate_r <= sfr_wdata_i;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Transmit buffer; a colliding write leaves it untouched
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            txbuf_r      <= spi_port_pkg::DAT_RESET;
            txbuf_full_r <= 1'b0;
        end else if (dat_accept) begin
            txbuf_r      <= sfr_wdata_i;
            txbuf_full_r <= 1'b1;
        end else if (move) begin
            txbuf_full_r <= 1'b0;
        end
    end

    // Receive buffer; a slave keeps the unread byte on overrun
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            rxbuf_r   <= spi_port_pkg::DAT_RESET;
            rx_full_r <= 1'b0;
        end else begin
            if (rd_dat) begin
                rx_full_r <= 1'b0;
            end
            if (m_done || (s_done && !rx_full_r)) begin
                rxbuf_r   <= rx_byte;
                rx_full_r <= !master_r;
            end
        end
    end

    // Shift register empty: set at byte end unless reloaded, cleared by load or clock edge;
    // the edge that ends a byte and the closing edge after it must not clear it, else a slave never reloads
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            shift_register_empty_r <= spi_port_pkg::CFG_RESET[spi_port_pkg::CFG_SHIFT_REGISTER_EMPTY];
        end else if (move) begin
            shift_register_empty_r <= 1'b0;
        end else if (done) begin
            shift_register_empty_r <= 1'b1;
        end else if (sck_edge && !tail_edge) begin
            shift_register_empty_r <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Master sequencer; aborts at once if disabled or demoted
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            m_state_r <= spi_port_pkg::M_IDLE;
        end else if (!enable_r || !master_r || fault) begin
            m_state_r <= spi_port_pkg::M_IDLE;
        end else begin
            case (m_state_r)
                spi_port_pkg::M_IDLE: begin
                    if (move) begin
                        m_state_r <= spi_port_pkg::M_LEAD;
                    end
                end
                spi_port_pkg::M_LEAD: begin
                    if (half_end) begin
                        m_state_r <= spi_port_pkg::M_TRAIL;
                    end
                end
                spi_port_pkg::M_TRAIL: begin
                    if (m_done) begin
                        m_state_r <= spi_port_pkg::M_IDLE;
                    end else if (half_end) begin
                        m_state_r <= spi_port_pkg::M_LEAD;
                    end
                end
                default: begin
                    m_state_r <= spi_port_pkg::M_IDLE;
                end
            endcase
        end
    end

    // Bit counter; a select line fall in multi-master mode, or disable, restarts the byte
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            bit_cnt_r <= 4'h0;
        end else if (!enable_r || sel_fall || done) begin
            bit_cnt_r <= 4'h0;
        end else if (m_sample || s_sample) begin
            bit_cnt_r <= bit_cnt_r + 4'h1;
        end
    end

    // Shift registers, most significant bit first
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            tx_sr_r <= 8'h00;
            rx_sr_r <= 8'h00;
        end else begin
            if (move) begin
                tx_sr_r <= txbuf_r;
            end else if ((m_sample && !m_done) || (s_shift && (bit_cnt_r != 4'h0))) begin
                tx_sr_r <= {tx_sr_r[6:0], 1'b0};
            end
            if (m_sample || s_sample) begin
                rx_sr_r <= rx_byte;
            end
        end
    end

    // Edge-detect history of the synchronised pins
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            sck_d_r <= spi_port_pkg::PIN_RESET[3];
            sel_d_r <= spi_port_pkg::PIN_RESET[0];
        end else begin
            sck_d_r <= sck_s;
            sel_d_r <= sel_s;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Link outputs; clock idles at polarity, lead half inverted for phase one
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            sck_o         <= 1'b0;
            sck_oe_o      <= 1'b0;
            mosi_o        <= 1'b0;
            mosi_oe_o     <= 1'b0;
            miso_o        <= 1'b0;
            miso_oe_o     <= 1'b0;
            sel_line_o    <= 1'b0;
            sel_line_oe_o <= 1'b0;
        end else begin
            sck_o         <= cpol_r ^ ((m_state_r != spi_port_pkg::M_IDLE) &&
                                       (cpha_r ^ (m_state_r == spi_port_pkg::M_TRAIL)));
            sck_oe_o      <= enable_r && master_r;
            mosi_o        <= tx_sr_r[7];
            mosi_oe_o     <= enable_r && master_r;
            miso_o        <= tx_sr_r[7];
            miso_oe_o     <= slave_act;
            sel_line_o    <= mode_r[0];
            sel_line_oe_o <= mode_r[1];
        end
    end

    // Status words and read data; unmapped addresses read zero
    assign cfg_val = {(m_state_r != spi_port_pkg::M_IDLE) || (bit_cnt_r != 4'h0),
                      master_r, cpha_r, cpol_r,
                      !sel_s,
                      sel_s,
                      shift_register_empty_r,
                      master_r || !rx_full_r};
    assign ctl_val = {done_flag_r, coll_flag_r, fault_flag_r, ovrn_flag_r, mode_r, !txbuf_full_r, enable_r};

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            sfr_rdata_o <= 8'h00;
        end else if (sfr_rd_i) begin
            case (sfr_addr_i)
                spi_port_pkg::CFG_ADDR: sfr_rdata_o <= cfg_val;
                spi_port_pkg::CTL_ADDR: sfr_rdata_o <= ctl_val;
                spi_port_pkg::CKR_ADDR: sfr_rdata_o <= rate_r;
                spi_port_pkg::DAT_ADDR: sfr_rdata_o <= rxbuf_r;
                default:                sfr_rdata_o <= 8'h00;
            endcase
        end
    end

    // Interrupt request from any sticky flag, gated by the enable input
    assign irq_o = int_enable_i && (done_flag_r || coll_flag_r || fault_flag_r || ovrn_flag_r);

    ////////////////////////////////////////////////////////////////////////////
    // Assertions
    done_sets_a: assert property (@(posedge clk_i) disable iff (rst_i)
        done |=> done_flag_r) else $error("done flag not set after byte");
    coll_keep_a: assert property (@(posedge clk_i) disable iff (rst_i)
        dat_coll |=> coll_flag_r && $stable(txbuf_r)) else $error("collision write not refused");
    fault_drop_a: assert property (@(posedge clk_i) disable iff (rst_i)
        fault |=> fault_flag_r && !master_r && !enable_r) else $error("mode fault not handled");
    ovrn_keep_a: assert property (@(posedge clk_i) disable iff (rst_i)
        s_done && !master_r && rx_full_r |=> ovrn_flag_r && $stable(rxbuf_r)) else $error("overrun lost old byte");
    irq_flag_a: assert property (@(posedge clk_i) disable iff (rst_i)
        int_enable_i && done_flag_r |-> irq_o) else $error("flag without interrupt");
    sck_idle_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (m_state_r == spi_port_pkg::M_IDLE) [*2] |-> sck_o == $past(cpol_r)) else $error("clock not idle level");
    busy_flag_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (m_state_r != spi_port_pkg::M_IDLE) |-> cfg_val[spi_port_pkg::CFG_BUSY]) else $error("busy clear in transfer");
    half_min_a: assert property (@(posedge clk_i) disable iff (rst_i)
        $rose(m_state_r == spi_port_pkg::M_TRAIL) |-> !half_end [*3]) else $error("master half too short");
    rxe_master_a: assert property (@(posedge clk_i) disable iff (rst_i)
        master_r |-> cfg_val[spi_port_pkg::CFG_RXE]) else $error("receive empty low in master");
    txe_write_a: assert property (@(posedge clk_i) disable iff (rst_i)
        dat_accept |=> txbuf_full_r ##1 1'b1) else $error("transmit empty not cleared");
    sel_out_a: assert property (@(posedge clk_i) disable iff (rst_i)
        mode_r[1] ##1 $stable(mode_r) |-> sel_line_oe_o && (sel_line_o == mode_r[0])) else $error("select out wrong");
    shift_register_empty_done_a: assert property (@(posedge clk_i) disable iff (rst_i)
        done && !move |=> shift_register_empty_r) else $error("shift empty not set at byte end");

    master_byte_c: cover property (@(posedge clk_i) disable iff (rst_i) m_done);
    slave_byte_c:  cover property (@(posedge clk_i) disable iff (rst_i) s_done);
    mode_fault_c:  cover property (@(posedge clk_i) disable iff (rst_i) fault);
    overrun_c:     cover property (@(posedge clk_i) disable iff (rst_i) s_done && rx_full_r);

endmodule

/* verilog/spi_port_pkg.sv */
// Constants, register map and types shared by the serial port design files
package spi_port_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Register addresses on the special-function register port
    localparam logic [7:0] CFG_ADDR  = 8'hA1;
    localparam logic [7:0] CTL_ADDR  = 8'hF8;
    localparam logic [7:0] CKR_ADDR  = 8'hA2;
    localparam logic [7:0] DAT_ADDR  = 8'hA3;

    // Reset values
    localparam logic [7:0] CFG_RESET = 8'h07;
    localparam logic [7:0] CTL_RESET = 8'h06;
    localparam logic [7:0] CKR_RESET = 8'h00;
    localparam logic [7:0] DAT_RESET = 8'h00;

    // Configuration register fields
    localparam int CFG_BUSY   = 7;
    localparam int CFG_MASTER = 6;
    localparam int CFG_CPHA   = 5;
    localparam int CFG_CPOL   = 4;
    localparam int CFG_SELECT = 3;
    localparam int CFG_RAWSEL = 2;
    localparam int CFG_SHIFT_REGISTER_EMPTY   = 1;
    localparam int CFG_RXE    = 0;

    // Control register fields
    localparam int CTL_DONE   = 7;
    localparam int CTL_COLL   = 6;
    localparam int CTL_FAULT  = 5;
    localparam int CTL_OVRN   = 4;
    localparam int CTL_MODE_H = 3;
    localparam int CTL_MODE_L = 2;
    localparam int CTL_TXE    = 1;
    localparam int CTL_EN     = 0;

    // Select line modes
    localparam logic [1:0] MODE_3WIRE = 2'b00;
    localparam logic [1:0] MODE_MULTI = 2'b01;

    ////////////////////////////////////////////////////////////////////////////
    // Timing: system clock and fastest allowed master bit period
    localparam int CLK_PERIOD_NS     = 10;
    localparam int MIN_BIT_PERIOD_NS = 80;
    localparam int MIN_HALF_CYC      = (MIN_BIT_PERIOD_NS / 2 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [8:0] MIN_HALF  = 9'(MIN_HALF_CYC);
    localparam logic [3:0] BYTE_BITS = 4'h8;

    // Link pin synchroniser reset pattern {sck, mosi, miso, select}
    localparam logic [3:0] PIN_RESET = 4'h1;

    // Master sequencer: lead half and trail half of each bit
    typedef enum logic [1:0] {M_IDLE, M_LEAD, M_TRAIL} m_state_t;

endpackage

/* verilog/pin_sync.sv */
// Two-flop synchroniser for the four link pins
`timescale 1ns/1ps
module pin_sync (
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic [3:0] pins_i,
    output logic      [3:0] pins_o
);
    logic [3:0] meta_r;

    // First stage feeds only the second stage
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            meta_r <= spi_port_pkg::PIN_RESET;
            pins_o <= spi_port_pkg::PIN_RESET;
        end else begin
            meta_r <= pins_i;
            pins_o <= meta_r;
        end
    end
endmodule

/* verilog/sck_half_timer.sv */
// Half bit period timer for master clock generation
`timescale 1ns/1ps
module sck_half_timer (
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic       run_i,
    input  wire logic [8:0] half_len_i,
    output logic            half_end_o
);
    logic [8:0] cnt_r;

    // Pulse on the last cycle of each half period
    assign half_end_o = run_i && (cnt_r == half_len_i - 9'h001);

    // Restarts whenever the master sequencer stops
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            cnt_r <= 9'h000;
        end else if (!run_i || half_end_o) begin
            cnt_r <= 9'h000;
        end else begin
            cnt_r <= cnt_r + 9'h001;
        end
    end
endmodule

/* bench/spi_far_slave.sv */
// Far-side serial slave model that answers the port in master mode
`timescale 1ns/1ps
module spi_far_slave (
    input  wire logic       sck_i,
    input  wire logic       act_i,
    input  wire logic       mosi_i,
    input  wire logic       cpol_i,
    input  wire logic       cpha_i,
    input  wire logic [7:0] tx_i,
    output logic            miso_o,
    output logic      [7:0] rx_o
);
    int cnt = 0;
    // Frame start puts the MSB out; a released line flips so stale data never passes
    always @(act_i) begin
        cnt = 0;
        miso_o = act_i ? tx_i[7] : ~miso_o;
    end
    // Same phase and polarity as the port; edges outside a frame are ignored
    always @(sck_i) begin
        if (act_i === 1'b1) begin
            if ((sck_i != cpol_i) ^ cpha_i) begin
                rx_o = {rx_o[6:0], mosi_i};
                cnt = (cnt + 1) % 8;
            end else begin
                miso_o = tx_i[7 - cnt];
            end
        end
    end
endmodule

/* bench/tb_top.sv */
// Bench: master bytes in all clock modes, mode fault, slave bytes and overrun
`timescale 1ns/1ps
module tb_top;
    logic        clk_i = 0, rst_i = 1, sfr_wr_i = 0, sfr_rd_i = 0, int_enable_i = 0, sck_i = 0;
    logic        mosi_i = 0, sel_line_i = 1, cpol = 0, cpha = 0, rd_seen = 0, far_miso;
    logic        irq_o, sck_o, sck_oe_o, mosi_o, mosi_oe_o, miso_o, miso_oe_o, sel_line_o, sel_line_oe_o;
    logic [7:0]  sfr_addr_i = 8'h00, sfr_wdata_i = 8'h00, sfr_rdata_o, rx, ptx = 8'h00, d, b, got;
    logic [23:0] q[$];
    int          n_mismatch = 0, check_count = 0, cyc = 0, seed = 78157;

    spi_port spi_port_inst (.clk_i, .rst_i, .sfr_addr_i, .sfr_wr_i, .sfr_rd_i, .sfr_wdata_i, .sfr_rdata_o,
        .int_enable_i, .irq_o, .sck_i, .sck_o, .sck_oe_o, .mosi_i, .mosi_o, .mosi_oe_o, .miso_i(far_miso),
        .miso_o, .miso_oe_o, .sel_line_i, .sel_line_o, .sel_line_oe_o);
    spi_far_slave spi_far_slave_inst (.sck_i(sck_o), .act_i(sck_oe_o & sel_line_oe_o & ~sel_line_o),
        .mosi_i(mosi_o), .cpol_i(cpol), .cpha_i(cpha), .tx_i(ptx), .miso_o(far_miso), .rx_o(rx));

    initial forever #5 clk_i = ~clk_i;

    task automatic give_verdict;
        if (n_mismatch == 0 && check_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic cmp(string nm, logic [7:0] e, logic [7:0] g);
        check_count++;
        if (g !== e) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask
    // Second write one cycle later hits a still-full buffer
    task automatic wr(logic [7:0] a, logic [7:0] v, bit twice = 0);
        @(posedge clk_i);
        sfr_addr_i  <= a;
        sfr_wdata_i <= v;
        sfr_wr_i    <= 1'b1;
        if (twice) @(posedge clk_i) sfr_wdata_i <= ~v;
        @(posedge clk_i);
        sfr_wr_i <= 1'b0;
    endtask
    // Expected value is noted; the monitor compares when the data shows
    task automatic rd(logic [7:0] a, logic [7:0] m, logic [7:0] e);
        @(posedge clk_i);
        sfr_addr_i <= a;
        sfr_rd_i   <= 1'b1;
        q.push_back({a, m, e & m});
        @(posedge clk_i);
        sfr_rd_i <= 1'b0;
    endtask
    // Bench as master, 160 ns bit, well inside the slave's rate limit
    task automatic sbyte(logic [7:0] v);
        for (int i = 7; i >= 0; i--) begin
            @(posedge clk_i) mosi_i <= v[i];
            sck_i <= cpol ^ cpha;
            repeat (7) @(posedge clk_i);
            sck_i <= ~(cpol ^ cpha);
            got[i] = miso_o;
            repeat (8) @(posedge clk_i);
            sck_i <= cpol;
        end
        mosi_i <= ~mosi_i;
        repeat (6) @(posedge clk_i);
    endtask

    // Read data lands one cycle after the strobe
    always @(posedge clk_i) begin
        if (rd_seen) begin
            cmp($sformatf("reg %h", q[0][23:16]), q[0][7:0], q[0][15:8] & sfr_rdata_o);
            void'(q.pop_front());
        end
        rd_seen = sfr_rd_i;
        cyc++;
        if (cyc == 5000) begin
            n_mismatch++;
            give_verdict;
        end
    end

    initial begin
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(spi_port_pkg::CFG_ADDR, 8'hFF, spi_port_pkg::CFG_RESET);
        rd(spi_port_pkg::CTL_ADDR, 8'hFF, spi_port_pkg::CTL_RESET);
        rd(8'h55, 8'hFF, 8'h00);
        for (int m = 0; m < 4; m++) begin
            wr(spi_port_pkg::CTL_ADDR, 8'h08);
            {cpha, cpol} = 2'(m);
            wr(spi_port_pkg::CFG_ADDR, 8'h40 | 8'(m << 4));
            wr(spi_port_pkg::CKR_ADDR, 8'($random(seed) & 3));
            ptx = 8'($random(seed));
            d = 8'($random(seed));
            int_enable_i <= 1'($random(seed));
            wr(spi_port_pkg::CTL_ADDR, 8'h09);
            wr(spi_port_pkg::DAT_ADDR, d, 1);
            repeat (100) @(posedge clk_i);
            cmp("far rx", d, rx);
            cmp("irq", {7'h00, int_enable_i}, {7'h00, irq_o});
            cmp("sck idle", {7'h00, cpol}, {7'h00, sck_o});
            cmp("mosi drive", 8'h01, {7'h00, mosi_oe_o});
            rd(spi_port_pkg::DAT_ADDR, 8'hFF, ptx);
            rd(spi_port_pkg::CTL_ADDR, 8'hC3, 8'hC3);
            rd(spi_port_pkg::CFG_ADDR, 8'h81, 8'h01);
            wr(spi_port_pkg::CTL_ADDR, 8'h09);
            rd(spi_port_pkg::CTL_ADDR, 8'hF0, 8'h00);
        end
        // Another master pulls the select line low
        wr(spi_port_pkg::CTL_ADDR, 8'h05);
        sel_line_i <= 1'b0;
        repeat (6) @(posedge clk_i);
        rd(spi_port_pkg::CTL_ADDR, 8'h21, 8'h20);
        rd(spi_port_pkg::CFG_ADDR, 8'h4C, 8'h08);
        // Slave: preload a reply, then a second byte without reading the first
        wr(spi_port_pkg::CFG_ADDR, 8'h00);
        {cpha, cpol} = 2'b00;
        wr(spi_port_pkg::CTL_ADDR, 8'h05);
        b = 8'($random(seed));
        wr(spi_port_pkg::DAT_ADDR, 8'hA5);
        sbyte(b);
        cmp("miso byte", 8'hA5, got);
        cmp("miso drive", 8'h01, {7'h00, miso_oe_o});
        rd(spi_port_pkg::CFG_ADDR, 8'h03, 8'h02);
        sbyte(~b);
        rd(spi_port_pkg::CTL_ADDR, 8'h90, 8'h90);
        rd(spi_port_pkg::DAT_ADDR, 8'hFF, b);
        rd(spi_port_pkg::CFG_ADDR, 8'h01, 8'h01);
        // Three-wire slave with phase and polarity set; clock idles high, reply loaded while disabled
        wr(spi_port_pkg::CTL_ADDR, 8'h00);
        {cpha, cpol} = 2'b11;
        sck_i <= 1'b1;
        wr(spi_port_pkg::CFG_ADDR, 8'h30);
        d = 8'($random(seed));
        wr(spi_port_pkg::DAT_ADDR, d);
        wr(spi_port_pkg::CTL_ADDR, 8'h01);
        sbyte(b ^ d);
        cmp("miso phase", d, got);
        rd(spi_port_pkg::DAT_ADDR, 8'hFF, b ^ d);
        repeat (2) @(posedge clk_i);
        give_verdict;
    end
endmodule
